// ---- hdl/rxro_consts.vh ----
`ifndef RXRO_CONSTS_VH
`define RXRO_CONSTS_VH

// Line mode encodings.
`define RXRO_MODE_DS3        2'h0
`define RXRO_MODE_STS1       2'h1
`define RXRO_MODE_E3         2'h2

// Reset values of line_codec_enable, monitor_mode_active and every other output except line_mode.
`define RXRO_RST_SINGLE_RAIL 1'h0
`define RXRO_RST_MONITOR     1'h0
`define RXRO_RST_OUT         1'h0
`define RXRO_RST_SFM         1'h0

// Bit positions of the strap pins in both synchroniser stages.
`define RXRO_PIN_HOST        3'h0
`define RXRO_PIN_RAIL        3'h1
`define RXRO_PIN_MONITOR     3'h2
`define RXRO_PIN_E3          3'h3
`define RXRO_PIN_STS1        3'h4
`define RXRO_PIN_SFM         3'h5

// Core clock and reference figures, in kHz.
`define RXRO_CORE_CLK_KHZ    25000
`define RXRO_SFM_REF_KHZ     12288

`endif

// ---- hdl/rxro_rail_out.v ----
// Behaviour
// - Dual-rail: received negative pulses drive the shared negative/violation output.
// - Host mode: rail format comes from a software control bit.
// - Single-rail: output pulses high per code violation, low otherwise.
// - Hardware mode: monitor select high enables monitoring mode.
// - Host mode: monitoring mode follows software control bit.
// - Host mode: monitor pin becomes serial data output.
// - Single-frequency mode: 12.288 MHz reference, rate clock synthesized internally.
// - Single-frequency mode: low-jitter clock output at the selected mode rate.
// - Single-frequency enable defaults off when unconnected.
// - E3 select high gives E3; else STS-1 high, DS3 low.
// - Single-rail enables the line decoder; dual-rail disables it.
// - Control mode select high is host mode, low hardware mode.
`timescale 1ns/1ps
`include "rxro_consts.vh"

module rxro_rail_out
(
    // Clock and reset
    input  wire       core_clk,
    input  wire       srst,
    // Pins sampled from outside the clock domain
    input  wire       control_mode_select,
    input  wire       rail_format_select,
    input  wire       monitor_mode_select,
    input  wire       e_three_select,
    input  wire       sonet_or_t3_select,
    input  wire       single_freq_enable,
    // Host control bits from the serial register file
    input  wire       host_single_rail,
    input  wire       host_monitor_en,
    input  wire       serial_port_data_out,
    // Receive data from the line decoder, one cycle per recovered bit
    input  wire       rx_bit_strobe,
    input  wire       receive_negative_rail,
    input  wire       code_violation_flag,
    // Outputs to the framer
    output reg        neg_rail_or_violation_out,
    // Monitor pin as two signals
    output reg        monitor_pin_out,
    output reg        monitor_pin_oe,
    // Status and clock steering
    output reg        monitor_mode_active,
    output reg        line_codec_enable,
    output reg  [1:0] line_mode,
    output reg        synth_enable,
    output reg        clk_out_enable
);

    // Two flip-flops per strap pin; logic reads only the second stage.
    reg [5:0] sync1_reg;
    reg [5:0] sync2_reg;

    wire host_mode   = sync2_reg[`RXRO_PIN_HOST];
    wire hw_rail     = sync2_reg[`RXRO_PIN_RAIL];
    wire hw_monitor  = sync2_reg[`RXRO_PIN_MONITOR];
    wire pin_e3      = sync2_reg[`RXRO_PIN_E3];
    wire pin_sts1    = sync2_reg[`RXRO_PIN_STS1];
    // An unconnected enable is pulled low on the pad, so reset also holds it off.
    wire pin_sfm     = sync2_reg[`RXRO_PIN_SFM];

    // Host mode takes the software bit, hardware mode the strap pin.
    function select_source;
        input host;
        input soft_bit;
        input pin_bit;
        begin
            if (host)
                select_source = soft_bit;
            else
                select_source = pin_bit;
        end
    endfunction

    wire single_rail = select_source(host_mode, host_single_rail, hw_rail);
    wire monitor_on  = select_source(host_mode, host_monitor_en, hw_monitor);

    function [1:0] mode_decode;
        input e3;
        input sts1;
        begin
            if (e3)
                mode_decode = `RXRO_MODE_E3;
            else if (sts1)
                mode_decode = `RXRO_MODE_STS1;
            else
                mode_decode = `RXRO_MODE_DS3;
        end
    endfunction

    // First stage takes the raw pins; nothing but the second stage reads it.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1_reg <= 6'h00;
        end
        else
        begin
            sync1_reg[`RXRO_PIN_HOST]    <= control_mode_select;
            sync1_reg[`RXRO_PIN_RAIL]    <= rail_format_select;
            sync1_reg[`RXRO_PIN_MONITOR] <= monitor_mode_select;
            sync1_reg[`RXRO_PIN_E3]      <= e_three_select;
            sync1_reg[`RXRO_PIN_STS1]    <= sonet_or_t3_select;
            sync1_reg[`RXRO_PIN_SFM]     <= single_freq_enable;
        end
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            sync2_reg <= 6'h00;
        end
        else
        begin
            sync2_reg <= sync1_reg;
        end
    end

    // One cycle per strobe, so a downstream counter never counts a bit twice.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            neg_rail_or_violation_out <= `RXRO_RST_OUT;
        end
        else if (single_rail)
        begin
            neg_rail_or_violation_out <= rx_bit_strobe & code_violation_flag;
        end
        else
        begin
            neg_rail_or_violation_out <= rx_bit_strobe & receive_negative_rail;
        end
    end

    // The line decoder runs only when the violation flag, not the negative rail, is wanted.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            line_codec_enable <= `RXRO_RST_SINGLE_RAIL;
        end
        else
        begin
            line_codec_enable <= single_rail;
        end
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            monitor_mode_active <= `RXRO_RST_MONITOR;
        end
        else
        begin
            monitor_mode_active <= monitor_on;
        end
    end

    // In hardware mode the same pad is the monitor strap, so it must not be driven.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            monitor_pin_oe <= `RXRO_RST_OUT;
        end
        else
        begin
            monitor_pin_oe <= host_mode;
        end
    end

    // Held low while not driving, so enabling the pad never shows a stale bit.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            monitor_pin_out <= `RXRO_RST_OUT;
        end
        else
        begin
            monitor_pin_out <= host_mode & serial_port_data_out;
        end
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            line_mode <= `RXRO_MODE_DS3;
        end
        else
        begin
            line_mode <= mode_decode(pin_e3, pin_sts1);
        end
    end

    // Reset holds the synthesizer off, matching an enable pin left floating.
    always @(posedge core_clk)
    begin
        if (srst)
        begin
            synth_enable <= `RXRO_RST_SFM;
        end
        else
        begin
            synth_enable <= pin_sfm;
        end
    end

    always @(posedge core_clk)
    begin
        if (srst)
        begin
            clk_out_enable <= `RXRO_RST_SFM;
        end
        else
        begin
            clk_out_enable <= pin_sfm;
        end
    end

endmodule // rxro_rail_out

// ---- verification/rxro_framer_model.sv ----
`timescale 1ns/1ps
module rxro_framer_model
(
    input  logic core_clk, srst, neg_rail_or_violation_out,
    output int   pulse_count
);
    // Counting on the clock edge means a pulse that lasts two cycles counts twice.
    always @(posedge core_clk)
        if (srst)
            pulse_count <= 0;
        else
            pulse_count <= pulse_count + int'(neg_rail_or_violation_out);
endmodule // rxro_framer_model

// ---- verification/rxro_rail_out_properties.sv ----
`timescale 1ns/1ps
module rxro_rail_out_properties
(
    input logic core_clk, srst, control_mode_select, single_freq_enable, rx_bit_strobe,
    receive_negative_rail, code_violation_flag, serial_port_data_out, neg_rail_or_violation_out,
    monitor_pin_out, monitor_pin_oe, line_codec_enable, clk_out_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_viol_out: assert property (rx_bit_strobe && code_violation_flag
        ##1 line_codec_enable |-> neg_rail_or_violation_out) else $error("no pulse");
    a_neg_out: assert property (rx_bit_strobe && receive_negative_rail
        ##1 !line_codec_enable |-> neg_rail_or_violation_out) else $error("no pulse");
    a_idle_low: assert property (!rx_bit_strobe |=> !neg_rail_or_violation_out)
        else $error("stray pulse");
    a_host_oe: assert property (control_mode_select[*4] |-> monitor_pin_oe)
        else $error("pin idle");
    a_hw_oe: assert property ((!control_mode_select)[*4] |-> !monitor_pin_oe)
        else $error("pin driven");
    a_host_bit: assert property (monitor_pin_oe
        |-> monitor_pin_out == $past(serial_port_data_out)) else $error("bad bit");
    a_sfm_on: assert property (single_freq_enable[*4] |-> clk_out_enable)
        else $error("no clock");
    a_sfm_off: assert property ((!single_freq_enable)[*4] |-> !clk_out_enable)
        else $error("clock on");
    c_viol: cover property (rx_bit_strobe && code_violation_flag);
    c_host: cover property (monitor_pin_oe);
    c_sfm: cover property (clk_out_enable);
endmodule // rxro_rail_out_properties
bind rxro_rail_out rxro_rail_out_properties rxro_rail_out_properties_i (.*);

// ---- verification/rxro_rail_out_test.sv ----
`timescale 1ns/1ps
`include "rxro_consts.vh"
module rxro_rail_out_test;
    logic core_clk = 0, srst = 1, control_mode_select = 0, rail_format_select = 1, exp_q = 0;
    logic monitor_mode_select = 1, e_three_select = 1, sonet_or_t3_select = 0;
    logic single_freq_enable = 1, host_single_rail = 1, host_monitor_en = 1;
    logic serial_port_data_out = 0, rx_bit_strobe = 0, receive_negative_rail = 0;
    logic code_violation_flag = 0, neg_rail_or_violation_out, monitor_pin_out, monitor_pin_oe;
    logic monitor_mode_active, line_codec_enable, synth_enable, clk_out_enable;
    logic [1:0] line_mode;
    // Rail pin, strobe, negative, violation, expected output; zeros let the pins settle.
    logic [4:0] sq [18] = '{5'h10, 5'h10, 5'h10, 5'h10, 5'h1F, 5'h1C, 5'h1B, 5'h12, 5'h10,
        5'h00, 5'h00, 5'h00, 5'h00, 5'h0D, 5'h0A, 5'h0F, 5'h04, 5'h00};
    int err_total = 0, n_checks = 0, cyc = 0, pulse_count;
    rxro_rail_out rxro_rail_out_i (.*);
    rxro_framer_model rxro_framer_model_i (.*);
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 300)
        begin
            err_total++;
            wrap_up;
        end
    end
    task chk(string nm, logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task step(logic [4:0] v);
        @(negedge core_clk);
        chk("rail", neg_rail_or_violation_out, exp_q);
        {rail_format_select, rx_bit_strobe, receive_negative_rail, code_violation_flag,
            exp_q} = v;
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        repeat (13) @(negedge core_clk);
        srst = 0;
        foreach (sq[i]) step(sq[i]);
        chk("count", pulse_count, 4);
        chk("hw", {monitor_mode_active, line_codec_enable, line_mode, synth_enable,
            clk_out_enable}, {2'h2, `RXRO_MODE_E3, 2'h3});
        {control_mode_select, serial_port_data_out, monitor_mode_select, e_three_select,
            sonet_or_t3_select, single_freq_enable} = 6'h32;
        repeat (4) @(negedge core_clk);
        chk("host", {monitor_pin_oe, monitor_pin_out, line_codec_enable, monitor_mode_active,
            line_mode, clk_out_enable}, {4'hF, `RXRO_MODE_STS1, 1'h0});
        {serial_port_data_out, host_monitor_en, host_single_rail} = 3'h0;
        @(negedge core_clk);
        chk("host off", {monitor_pin_out, monitor_mode_active, line_codec_enable}, 3'h0);
        {control_mode_select, sonet_or_t3_select, monitor_mode_select, single_freq_enable} = 4'h3;
        repeat (4) @(negedge core_clk);
        chk("hw ds3", {monitor_pin_oe, monitor_mode_active, line_codec_enable, line_mode,
            clk_out_enable}, {3'h2, `RXRO_MODE_DS3, 1'h1});
        srst = 1;
        @(negedge core_clk);
        chk("reset", {neg_rail_or_violation_out, monitor_pin_oe, monitor_mode_active,
            line_codec_enable, line_mode, synth_enable, clk_out_enable}, 8'h00);
        srst = 0;
        repeat (2) @(negedge core_clk);
        chk("sync", {synth_enable, clk_out_enable}, 2'h0);
        repeat (2) @(negedge core_clk);
        chk("sfm", {synth_enable, clk_out_enable, monitor_mode_active}, 3'h7);
        wrap_up;
    end
endmodule // rxro_rail_out_test
